// [pkg/scan_seq_pkg.sv]
// constants and types shared by the relay scan sequencer
package scan_seq_pkg;
  // ----------------------------------------
  // register byte addresses on the apb side
  // ----------------------------------------
  localparam logic [7:0] ADDR_CMD = 8'h00; // command word, write only
  localparam logic [7:0] ADDR_STAT = 8'h04; // status, write 1 clears flags
  localparam logic [7:0] ADDR_CFG = 8'h08; // settings readback
  localparam logic [7:0] ADDR_QRY = 8'h0c; // last query answer
  // ----------------------------------------
  // command word layout
  // ----------------------------------------
  localparam int LINK_LO = 0;
  localparam int LINK_HI = 1;
  localparam int KIND_LO = 2;
  localparam int KIND_HI = 3;
  localparam int SUB_LO = 4;
  localparam int SUB_HI = 7;
  localparam int LEAF_LO = 8;
  localparam int LEAF_HI = 11;
  localparam int ARG_LO = 16;
  localparam int ARG_HI = 31;
  localparam int ENT_CHAN_HI = 5; // list entry: channel in arg[5:0]
  localparam int ENT_CARD_LO = 6; // list entry: card in arg[12:6]
  localparam int ENT_CARD_HI = 12;
  localparam int LINE_HI = 2; // trigger source arg: line in arg[2:0]
  localparam int SRC_LO = 4; // trigger source arg: code in arg[6:4]
  localparam int SRC_HI = 6;
  // link of a command to the one before it on the line
  localparam logic [1:0] LINK_ROOT = 2'h0; // first on a line
  localparam logic [1:0] LINK_SAME = 2'h1; // after a bare semicolon
  localparam logic [1:0] LINK_REROOT = 2'h2; // after semicolon and colon
  localparam logic [1:0] LINK_COMMON = 2'h3; // star-prefixed common command
  // argument kinds
  localparam logic [1:0] KIND_NUM = 2'h0;
  localparam logic [1:0] KIND_MIN = 2'h1;
  localparam logic [1:0] KIND_MAX = 2'h2;
  localparam logic [1:0] KIND_AUTO = 2'h3;
  // subsystems, and common operations in the same field
  localparam logic [3:0] SUB_ARM = 4'h1;
  localparam logic [3:0] SUB_DISP = 4'h2;
  localparam logic [3:0] SUB_INIT = 4'h3;
  localparam logic [3:0] SUB_ABORT = 4'h4;
  localparam logic [3:0] SUB_TRIG = 4'h5;
  localparam logic [3:0] SUB_ROUTE = 4'h6;
  localparam logic [3:0] COM_RST = 4'h1;
  localparam logic [3:0] COM_TRG = 4'h2;
  // leaves inside a subsystem
  localparam logic [3:0] LF_COUNT = 4'h0; // arm count set
  localparam logic [3:0] LF_COUNT_Q = 4'h1; // arm count query
  localparam logic [3:0] LF_MON_CARD = 4'h0; // monitor card select
  localparam logic [3:0] LF_MON_STATE = 4'h1; // monitor on/off
  localparam logic [3:0] LF_CONT = 4'h0; // continuous on/off
  localparam logic [3:0] LF_CONT_Q = 4'h1; // continuous query
  localparam logic [3:0] LF_IMM = 4'h2; // initiate
  localparam logic [3:0] LF_SOURCE = 4'h0; // trigger source
  localparam logic [3:0] LF_CLOSE = 4'h0; // close one channel
  localparam logic [3:0] LF_SCAN_CLR = 4'h1; // empty the channel list
  localparam logic [3:0] LF_SCAN_ADD = 4'h2; // append one list entry
  // trigger sources
  localparam logic [2:0] SRC_IMM = 3'h0;
  localparam logic [2:0] SRC_BUS = 3'h1;
  localparam logic [2:0] SRC_EXT = 3'h2;
  localparam logic [2:0] SRC_HOLD = 3'h3;
  localparam logic [2:0] SRC_LINE = 3'h4;
  // ranges and reset values
  localparam logic [14:0] CNT_MIN = 15'h0001;
  localparam logic [14:0] CNT_MAX = 15'h7fff;
  localparam logic [6:0] CARD_MIN = 7'h01;
  localparam logic [6:0] CARD_MAX = 7'h63;
  localparam logic [5:0] CHAN_MAX = 6'h1f;
  localparam int LIST_DEPTH = 8;
  localparam logic [3:0] LIST_FULL = 4'h8;
  // scan sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } scan_state_t;
endpackage

// [rtl/relay_scan_seq.sv]
// relay scan sequencer with linked command decode and apb registers
//
// Overview of operation
// - common and subsystem commands run in order
// - semicolon-colon link restarts at root level
// - bare semicolon keeps the previous subsystem
// - abort stops bus/hold scan, kills list
// - interface clear stops a running scan
// - noncontinuous scan repeats 1..32767 cycles
// - counts outside 1..32767 are rejected
// - count query answers current, 1, 32767
// - monitor card 1..99 or auto-tracked
// - monitor mode switched by boolean argument
// - monitor shows closed channels of card
// - continuous scan wraps to first channel
// - finished noncontinuous scan opens last channel
// - continuous query answers 1 or 0
// - initiate closes first, trigger advances one
// - initiate with bad list flags error
// - immediate trigger source is the default
// - source is bus, ext, hold, imm, line
// - entries are card 01..99, channel 00..31
`timescale 1ns/1ps
`default_nettype none
module relay_scan_seq
  import scan_seq_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trigger and clear pins, asynchronous
  input wire logic ext_trig_in,
  input wire logic [7:0] backplane_trigger_line,
  input wire logic ifc_clear_in,
  // relay drive and monitor display
  output logic scan_active,
  output logic relay_close,
  output logic [6:0] relay_card,
  output logic [4:0] relay_chan,
  output logic mon_enable,
  output logic [6:0] mon_card,
  output logic [31:0] mon_mask
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // card number inside the addressable range
  function automatic logic card_ok(input logic [6:0] c);
    card_ok = (c >= CARD_MIN) && (c <= CARD_MAX);
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [9:0] sync1_ff; // first stage, read only by sync2_ff
  logic [9:0] sync2_ff; // settled copy of {ifc, ext, lines}
  logic [9:0] sync3_ff; // delayed copy for edge detection
  logic [9:0] nxt_sync1, nxt_sync2, nxt_sync3;
  logic [9:0] pin_rise; // rising edges of the settled pins

  // two flops before any logic looks at a pin
  always_comb begin
    nxt_sync1 = {ifc_clear_in, ext_trig_in, backplane_trigger_line};
    nxt_sync2 = sync1_ff;
    nxt_sync3 = sync2_ff;
    pin_rise = sync2_ff & ~sync3_ff;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      sync3_ff <= nxt_sync3;
    end
  end

  // ----------------------------------------
  // sequencer state
  // ----------------------------------------
  scan_state_t state_ff, nxt_state;
  logic [3:0] ctx_ff, nxt_ctx; // subsystem of the last command
  logic [14:0] count_ff, nxt_count; // cycles per initiate
  logic [14:0] cycles_ff, nxt_cycles; // cycles finished so far
  logic cont_ff, nxt_cont; // continuous scanning
  logic mon_ff, nxt_mon; // monitor mode
  logic auto_ff, nxt_auto; // monitor follows last switched card
  logic [6:0] sel_card_ff, nxt_sel_card; // fixed monitor card
  logic [6:0] last_card_ff, nxt_last_card; // last switched card
  logic [2:0] src_ff, nxt_src; // trigger source
  logic [2:0] line_ff, nxt_line; // backplane line number
  logic [6:0] lcard_ff [LIST_DEPTH]; // channel list storage
  logic [4:0] lchan_ff [LIST_DEPTH];
  logic [6:0] nxt_lcard [LIST_DEPTH];
  logic [4:0] nxt_lchan [LIST_DEPTH];
  logic [3:0] len_ff, nxt_len; // entries in the list
  logic list_ok_ff, nxt_list_ok; // list definition is valid
  logic [2:0] idx_ff, nxt_idx; // entry now closed
  logic [2:0] err_ff, nxt_err; // sticky {cmd, list, count} errors
  logic [15:0] qry_ff, nxt_qry; // last query answer
  logic run_ff, close_ff, ren_ff;
  logic [6:0] rcard_ff, mcard_ff;
  logic [4:0] rchan_ff;
  logic [31:0] mask_ff, nxt_mask;
  logic [6:0] nxt_mcard;
  logic nxt_close; // next relay drive
  logic [6:0] nxt_rcard; // next closed card
  logic [4:0] nxt_rchan; // next closed channel
  // decode of the command being written
  logic cmd_fire, is_common, bus_trg, trig, stop_req, at_last, last_cycle;
  logic [3:0] sub, leaf;
  logic [1:0] kind;
  logic [15:0] arg;
  logic [6:0] ecard;
  logic [5:0] echan;
  logic [2:0] stat_clr;

  // command word decode and trigger selection
  always_comb begin
    cmd_fire = psel & penable & pready & pwrite & (paddr == ADDR_CMD);
    stat_clr = '0;
    if (psel & penable & pready & pwrite & (paddr == ADDR_STAT)) begin
      stat_clr = pwdata[2:0];
    end
    is_common = pwdata[LINK_HI:LINK_LO] == LINK_COMMON;
    // bare semicolon reuses the stored subsystem
    sub = (pwdata[LINK_HI:LINK_LO] == LINK_SAME) ? ctx_ff : pwdata[SUB_HI:SUB_LO];
    leaf = pwdata[LEAF_HI:LEAF_LO];
    kind = pwdata[KIND_HI:KIND_LO];
    arg = pwdata[ARG_HI:ARG_LO];
    ecard = arg[ENT_CARD_HI:ENT_CARD_LO];
    echan = arg[ENT_CHAN_HI:0];
    bus_trg = cmd_fire & is_common & (pwdata[SUB_HI:SUB_LO] == COM_TRG);
    // the selected source drives the scan
    case (src_ff)
      SRC_IMM: trig = 1'b1; // internal trigger every cycle
      SRC_BUS: trig = bus_trg;
      SRC_EXT: trig = pin_rise[8];
      SRC_LINE: trig = pin_rise[line_ff];
      default: trig = 1'b0; // hold: only abort, clear or common reset end it
    endcase
    // abort acts only for bus or hold; clear always
    stop_req = (cmd_fire & ~is_common & (sub == SUB_ABORT) & ((src_ff == SRC_BUS) | (src_ff == SRC_HOLD)))
      | sync2_ff[9];
    at_last = {1'b0, idx_ff} == (len_ff - 4'h1);
    last_cycle = (cycles_ff + 15'h0001) == count_ff;
  end

  // next values of the sequencer and the settings
  always_comb begin
    nxt_state = state_ff;
    nxt_ctx = ctx_ff;
    nxt_count = count_ff;
    nxt_cycles = cycles_ff;
    nxt_cont = cont_ff;
    nxt_mon = mon_ff;
    nxt_auto = auto_ff;
    nxt_sel_card = sel_card_ff;
    nxt_last_card = last_card_ff;
    nxt_src = src_ff;
    nxt_line = line_ff;
    nxt_lcard = lcard_ff;
    nxt_lchan = lchan_ff;
    nxt_len = len_ff;
    nxt_list_ok = list_ok_ff;
    nxt_idx = idx_ff;
    nxt_err = err_ff & ~stat_clr;
    nxt_qry = qry_ff;
    nxt_close = close_ff;
    nxt_rcard = rcard_ff;
    nxt_rchan = rchan_ff;
    // one command per write keeps linked commands in order
    if (cmd_fire & is_common) begin
      if (pwdata[SUB_HI:SUB_LO] == COM_RST) begin
        nxt_state = ST_IDLE; // common reset restores defaults
        nxt_count = CNT_MIN;
        nxt_cont = 1'b0;
        nxt_mon = 1'b0;
        nxt_auto = 1'b1;
        nxt_src = SRC_IMM;
        nxt_close = 1'b0;
      end
    end else if (cmd_fire) begin
      nxt_ctx = sub; // root or re-rooted link names its own subsystem
      if (sub == SUB_ARM && leaf == LF_COUNT) begin
        if (kind == KIND_MIN) begin
          nxt_count = CNT_MIN;
        end else if (kind == KIND_MAX) begin
          nxt_count = CNT_MAX;
        end else if (kind == KIND_NUM && arg != 16'h0000 && !arg[15]) begin
          nxt_count = arg[14:0];
        end else begin
          nxt_err[0] = 1'b1; // out of range, count kept
        end
      end else if (sub == SUB_ARM && leaf == LF_COUNT_Q) begin
        nxt_qry = (kind == KIND_MIN) ? {1'b0, CNT_MIN} : (kind == KIND_MAX) ? {1'b0, CNT_MAX} : {1'b0, count_ff};
      end else if (sub == SUB_DISP && leaf == LF_MON_CARD) begin
        if (kind == KIND_AUTO) begin
          nxt_auto = 1'b1;
        end else if (card_ok(arg[6:0]) && arg[15:7] == 9'h000) begin
          nxt_auto = 1'b0;
          nxt_sel_card = arg[6:0];
        end else begin
          nxt_err[2] = 1'b1;
        end
      end else if (sub == SUB_DISP && leaf == LF_MON_STATE) begin
        nxt_mon = arg != 16'h0000; // any non-zero is on
      end else if (sub == SUB_INIT && leaf == LF_CONT) begin
        nxt_cont = arg != 16'h0000;
      end else if (sub == SUB_INIT && leaf == LF_CONT_Q) begin
        nxt_qry = {15'h0000, cont_ff};
      end else if (sub == SUB_INIT && leaf == LF_IMM && !stop_req) begin
        if (list_ok_ff && len_ff != 4'h0) begin
          nxt_state = ST_RUN; // close the first entry
          nxt_idx = '0;
          nxt_cycles = '0;
          nxt_close = 1'b1;
          nxt_rcard = lcard_ff[0];
          nxt_rchan = lchan_ff[0];
          nxt_last_card = lcard_ff[0];
        end else begin
          nxt_err[1] = 1'b1; // scan refused
        end
      end else if (sub == SUB_TRIG && leaf == LF_SOURCE) begin
        nxt_src = arg[SRC_HI:SRC_LO];
        nxt_line = arg[LINE_HI:0];
      end else if (sub == SUB_ROUTE && leaf == LF_CLOSE) begin
        if (card_ok(ecard) && echan <= CHAN_MAX) begin
          nxt_close = 1'b1;
          nxt_rcard = ecard;
          nxt_rchan = echan[4:0];
          nxt_last_card = ecard; // tracked for auto monitor
        end else begin
          nxt_err[2] = 1'b1;
        end
      end else if (sub == SUB_ROUTE && leaf == LF_SCAN_CLR && state_ff == ST_IDLE) begin
        nxt_len = '0;
        nxt_list_ok = 1'b1;
      end else if (sub == SUB_ROUTE && leaf == LF_SCAN_ADD && state_ff == ST_IDLE) begin
        // entry must be card 1..99, channel 0..31
        if (card_ok(ecard) && echan <= CHAN_MAX && len_ff != LIST_FULL) begin
          nxt_lcard[len_ff[2:0]] = ecard;
          nxt_lchan[len_ff[2:0]] = echan[4:0];
          nxt_len = len_ff + 4'h1;
        end else begin
          nxt_list_ok = 1'b0;
        end
      end else if (sub != SUB_ABORT) begin
        nxt_err[2] = 1'b1; // unknown command
      end
    end
    // stepping and stopping of a running scan
    if (state_ff == ST_RUN) begin
      if (stop_req) begin
        nxt_state = ST_IDLE;
        nxt_close = 1'b0;
        if (!sync2_ff[9]) begin
          nxt_list_ok = 1'b0; // abort invalidates the list
        end
      end else if (trig && !at_last) begin
        nxt_idx = idx_ff + 3'h1; // one entry per trigger
      end else if (trig && cont_ff) begin
        nxt_idx = '0; // wrap forever
      end else if (trig && last_cycle) begin
        nxt_state = ST_IDLE;
        nxt_close = 1'b0; // last entry opened at the end
      end else if (trig) begin
        nxt_idx = '0; // next of the programmed cycles
        nxt_cycles = cycles_ff + 15'h0001;
      end
      if (nxt_state == ST_RUN) begin
        nxt_rcard = lcard_ff[nxt_idx];
        nxt_rchan = lchan_ff[nxt_idx];
        nxt_last_card = lcard_ff[nxt_idx];
      end
    end
  end

  // monitor view of the closed channel on the shown card
  always_comb begin
    nxt_mcard = auto_ff ? last_card_ff : sel_card_ff;
    nxt_mask = '0;
    if (mon_ff && close_ff && rcard_ff == nxt_mcard) begin
      nxt_mask[rchan_ff] = 1'b1;
    end
  end

  // settings reset to their defaults
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      ctx_ff <= SUB_ROUTE;
      count_ff <= CNT_MIN;
      cycles_ff <= '0;
      cont_ff <= 1'b0;
      mon_ff <= 1'b0;
      auto_ff <= 1'b1;
      sel_card_ff <= CARD_MIN;
      last_card_ff <= CARD_MIN;
      src_ff <= SRC_IMM;
      line_ff <= '0;
      lcard_ff <= '{default: '0};
      lchan_ff <= '{default: '0};
      len_ff <= '0;
      list_ok_ff <= 1'b0;
      idx_ff <= '0;
      err_ff <= '0;
      qry_ff <= '0;
      run_ff <= 1'b0;
      close_ff <= 1'b0;
      rcard_ff <= '0;
      rchan_ff <= '0;
      ren_ff <= 1'b0;
      mcard_ff <= '0;
      mask_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      ctx_ff <= nxt_ctx;
      count_ff <= nxt_count;
      cycles_ff <= nxt_cycles;
      cont_ff <= nxt_cont;
      mon_ff <= nxt_mon;
      auto_ff <= nxt_auto;
      sel_card_ff <= nxt_sel_card;
      last_card_ff <= nxt_last_card;
      src_ff <= nxt_src;
      line_ff <= nxt_line;
      lcard_ff <= nxt_lcard;
      lchan_ff <= nxt_lchan;
      len_ff <= nxt_len;
      list_ok_ff <= nxt_list_ok;
      idx_ff <= nxt_idx;
      err_ff <= nxt_err;
      qry_ff <= nxt_qry;
      run_ff <= nxt_state == ST_RUN;
      close_ff <= nxt_close;
      rcard_ff <= nxt_rcard;
      rchan_ff <= nxt_rchan;
      ren_ff <= nxt_mon;
      mcard_ff <= nxt_mcard;
      mask_ff <= nxt_mask;
    end
  end

  // ----------------------------------------
  // apb slave, one wait-free access phase
  // ----------------------------------------
  logic [31:0] rdata_ff, nxt_rdata;
  logic rdy_ff, nxt_rdy, serr_ff, nxt_serr;

  // answer prepared in the setup cycle, shown in the access cycle
  always_comb begin
    nxt_rdy = psel & ~penable;
    nxt_serr = 1'b0;
    nxt_rdata = '0;
    if (psel & ~penable) begin
      if (paddr == ADDR_CMD) begin
        nxt_serr = ~pwrite; // command word cannot be read
      end else if (paddr == ADDR_STAT) begin
        nxt_rdata = {9'h000, cycles_ff, 1'b0, idx_ff, err_ff, run_ff};
      end else if (paddr == ADDR_CFG) begin
        nxt_rdata = {1'b0, line_ff, src_ff, sel_card_ff, auto_ff, mon_ff, cont_ff, count_ff};
      end else if (paddr == ADDR_QRY) begin
        nxt_rdata = {16'h0000, qry_ff};
      end else begin
        nxt_serr = 1'b1; // unmapped address
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata_ff <= '0;
      rdy_ff <= 1'b0;
      serr_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      rdy_ff <= nxt_rdy;
      serr_ff <= nxt_serr;
    end
  end

  // outputs straight from flops
  assign prdata = rdata_ff;
  assign pready = rdy_ff;
  assign pslverr = serr_ff;
  assign scan_active = run_ff;
  assign relay_close = close_ff;
  assign relay_card = rcard_ff;
  assign relay_chan = rchan_ff;
  assign mon_enable = ren_ff;
  assign mon_card = mcard_ff;
  assign mon_mask = mask_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_step_last;
    run_ff && !stop_req && trig && at_last;
  endsequence
  chk_count_range: assert property (count_ff >= CNT_MIN && count_ff <= CNT_MAX)
    else $error("arm count out of range");
  chk_abort_stops: assert property (run_ff && stop_req && !sync2_ff[9] |=> !run_ff && !list_ok_ff)
    else $error("abort did not end scan");
  chk_clear_stops: assert property (run_ff && sync2_ff[9] |=> !run_ff && !relay_close)
    else $error("interface clear did not stop scan");
  chk_init_closes: assert property (cmd_fire && !is_common && sub == SUB_INIT && leaf == LF_IMM && !run_ff
    && list_ok_ff && len_ff != 4'h0 && !stop_req |=> run_ff && relay_close && idx_ff == 3'h0)
    else $error("initiate did not close first entry");
  chk_init_refused: assert property (cmd_fire && !is_common && sub == SUB_INIT && leaf == LF_IMM && !run_ff
    && !list_ok_ff |=> !run_ff && err_ff[1])
    else $error("bad list not refused");
  chk_cont_wraps: assert property ((s_step_last and cont_ff) |=> run_ff && idx_ff == 3'h0)
    else $error("continuous scan did not wrap");
  chk_last_opens: assert property ((s_step_last and !cont_ff && last_cycle) |=> !run_ff ##1 !relay_close)
    else $error("final entry not opened");
  chk_imm_advance: assert property (run_ff && src_ff == SRC_IMM && !stop_req && !at_last
    |=> idx_ff == $past(idx_ff) + 3'h1)
    else $error("immediate trigger did not advance");
  chk_count_query: assert property (cmd_fire && !is_common && sub == SUB_ARM && leaf == LF_COUNT_Q
    && kind == KIND_MAX |=> qry_ff == {1'b0, CNT_MAX})
    else $error("max count query wrong");
  chk_monitor_off: assert property (!mon_ff |=> mon_mask == 32'h0000_0000)
    else $error("display shown with monitor off");
endmodule
`default_nettype wire

// [bench/scan_ctrl_model.sv]
// apb command source standing in for the remote controller
`timescale 1ns/1ps
`default_nettype none
module scan_ctrl_model (
  // clock
  input wire logic mclk,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ----------------------------------------
  // bus idle at time zero
  // ----------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // one transfer, request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data flips so a stale word is never mistaken for a live one
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// [bench/relay_scan_sequencer_control_tb_top.sv]
// self-checking bench for the relay scan sequencer
`timescale 1ns/1ps
`default_nettype none
module relay_scan_sequencer_control_tb_top import scan_seq_pkg::*;;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, ifc_clear_in;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, mon_mask;
  logic scan_active, relay_close, mon_enable, perr;
  logic [6:0] relay_card, mon_card;
  logic [4:0] relay_chan;
  logic [8:0] pins = 9'h000; // {ext trigger, backplane lines}
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  // 20 mhz clock
  always #25 mclk = ~mclk;
  // design, trigger pins driven from the bench
  relay_scan_seq relay_scan_seq_inst (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_trig_in(pins[8]), .backplane_trigger_line(pins[7:0]), .ifc_clear_in(ifc_clear_in),
    .scan_active(scan_active), .relay_close(relay_close), .relay_card(relay_card),
    .relay_chan(relay_chan), .mon_enable(mon_enable), .mon_card(mon_card), .mon_mask(mon_mask));
  scan_ctrl_model scan_ctrl_model_inst (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      err_total++;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [31:0] cmd(logic [1:0] lk, logic [1:0] kd, logic [3:0] sb, logic [3:0] lf,
                                      logic [15:0] ar);
    return {ar, 4'h0, lf, sb, kd, lk};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    scan_ctrl_model_inst.xfer(1'b1, a, d, q, perr);
  endtask
  task automatic rd(input logic [7:0] a);
    scan_ctrl_model_inst.xfer(1'b0, a, 32'h0000_0000, q, perr);
  endtask
  // root-level command with a numeric argument
  task automatic sc(input logic [3:0] sb, input logic [3:0] lf, input logic [15:0] ar);
    wr(ADDR_CMD, cmd(LINK_ROOT, KIND_NUM, sb, lf, ar));
  endtask
  // fresh list of n channels on one card
  task automatic mklist(input logic [6:0] card, input int n);
    sc(SUB_ROUTE, LF_SCAN_CLR, 16'h0000);
    for (int i = 0; i < n; i++) sc(SUB_ROUTE, LF_SCAN_ADD, {3'h0, card, 6'(i)});
  endtask
  // bus trigger linked as a common command
  task automatic trig();
    wr(ADDR_CMD, cmd(LINK_COMMON, KIND_NUM, COM_TRG, 4'h0, 16'h0000));
    repeat (3) @(posedge mclk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(ADDR_CFG);
    chk("cfg defaults", q & 32'h0e03_ffff, 32'h0002_0001);
    rd(8'h10);
    chk("unmapped err", {31'h0, perr}, 32'h0000_0001);
    rd(ADDR_CMD);
    chk("cmd read err", {31'h0, perr}, 32'h0000_0001);
    for (int c = 0; c < 5; c++) begin
      sc(SUB_TRIG, LF_SOURCE, {9'h000, 3'(c), 4'h0});
      rd(ADDR_CFG);
      chk("source", {29'h0, q[27:25]}, 32'(c));
    end
  endtask
  task automatic t_count();
    wr(ADDR_CMD, cmd(LINK_ROOT, KIND_MAX, SUB_ARM, LF_COUNT, 16'h0000));
    rd(ADDR_CFG);
    chk("count max", {17'h0, q[14:0]}, 32'h0000_7fff);
    wr(ADDR_CMD, cmd(LINK_ROOT, KIND_MIN, SUB_ARM, LF_COUNT_Q, 16'h0000));
    rd(ADDR_QRY);
    chk("query min", {16'h0, q[15:0]}, 32'h0000_0001);
    wr(ADDR_CMD, cmd(LINK_ROOT, KIND_MAX, SUB_ARM, LF_COUNT_Q, 16'h0000));
    rd(ADDR_QRY);
    chk("query max", {16'h0, q[15:0]}, 32'h0000_7fff);
    wr(ADDR_STAT, 32'h0000_0007);
    sc(SUB_ARM, LF_COUNT, 16'h8000);
    rd(ADDR_STAT);
    chk("count err", {31'h0, q[1]}, 32'h0000_0001);
    rd(ADDR_CFG);
    chk("count kept", {17'h0, q[14:0]}, 32'h0000_7fff);
    sc(SUB_ARM, LF_COUNT, 16'h0002);
    wr(ADDR_CMD, cmd(LINK_SAME, KIND_NUM, 4'h0, LF_COUNT_Q, 16'h0000));
    rd(ADDR_QRY);
    chk("query same", {16'h0, q[15:0]}, 32'h0000_0002);
  endtask
  task automatic t_cont();
    for (int b = 1; b >= 0; b--) begin
      sc(SUB_INIT, LF_CONT, 16'(b));
      wr(ADDR_CMD, cmd(LINK_REROOT, KIND_NUM, SUB_INIT, LF_CONT_Q, 16'h0000));
      rd(ADDR_QRY);
      chk("cont query", {16'h0, q[15:0]}, 32'(b));
    end
  endtask
  // noncontinuous bus-triggered scan, two cycles of three channels
  task automatic t_scan();
    mklist(7'h01, 3);
    sc(SUB_TRIG, LF_SOURCE, {9'h000, SRC_BUS, 4'h0});
    sc(SUB_INIT, LF_IMM, 16'h0000);
    repeat (3) @(posedge mclk);
    chk("first chan", {relay_close, scan_active, relay_card, relay_chan}, 32'h0000_3020);
    for (int k = 1; k < 6; k++) begin
      trig();
      chk("step chan", {27'h0, relay_chan}, 32'(k % 3));
    end
    trig();
    chk("end opens", {30'h0, relay_close, scan_active}, 32'h0000_0000);
  endtask
  // continuous bus scan wraps, then abort kills it and the list
  task automatic t_abort();
    mklist(7'h01, 2);
    sc(SUB_INIT, LF_CONT, 16'h0001);
    sc(SUB_INIT, LF_IMM, 16'h0000);
    trig();
    trig();
    chk("wrap chan", {26'h0, scan_active, relay_chan}, 32'h0000_0020);
    sc(SUB_ABORT, 4'h0, 16'h0000);
    repeat (3) @(posedge mclk);
    chk("abort stops", {31'h0, scan_active}, 32'h0000_0000);
    wr(ADDR_STAT, 32'h0000_0007);
    sc(SUB_INIT, LF_IMM, 16'h0000);
    rd(ADDR_STAT);
    chk("init refused", {28'h0, q[3:1], scan_active}, 32'h0000_0004);
  endtask
  // ext and line pins step the scan, then immediate runs until clear
  task automatic t_clear();
    mklist(7'h01, 2);
    sc(SUB_TRIG, LF_SOURCE, {9'h000, SRC_EXT, 4'h0});
    sc(SUB_INIT, LF_IMM, 16'h0000);
    pins <= 9'h100;
    repeat (5) @(posedge mclk);
    chk("ext step", {27'h0, relay_chan}, 32'h0000_0001);
    sc(SUB_TRIG, LF_SOURCE, {9'h000, SRC_LINE, 4'h3});
    pins <= 9'h108;
    repeat (5) @(posedge mclk);
    chk("line step", {27'h0, relay_chan}, 32'h0000_0000);
    sc(SUB_TRIG, LF_SOURCE, {9'h000, SRC_IMM, 4'h0});
    repeat (20) @(posedge mclk);
    chk("imm running", {31'h0, scan_active}, 32'h0000_0001);
    ifc_clear_in <= 1'b1;
    repeat (4) @(posedge mclk);
    ifc_clear_in <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("clear stops", {31'h0, scan_active}, 32'h0000_0000);
  endtask
  task automatic t_mon();
    sc(SUB_DISP, LF_MON_STATE, 16'h0001);
    wr(ADDR_CMD, cmd(LINK_ROOT, KIND_AUTO, SUB_DISP, LF_MON_CARD, 16'h0000));
    sc(SUB_ROUTE, LF_CLOSE, {3'h0, 7'h02, 6'h05});
    repeat (4) @(posedge mclk);
    chk("mon auto", {mon_enable, mon_card}, 32'h0000_0082);
    chk("mon mask", mon_mask, 32'h0000_0020);
    sc(SUB_DISP, LF_MON_CARD, 16'h0063);
    sc(SUB_DISP, LF_MON_STATE, 16'h0000);
    repeat (4) @(posedge mclk);
    chk("mon off", {23'h0, |mon_mask, mon_enable, mon_card}, 32'h0000_0063);
    wr(ADDR_CMD, cmd(LINK_COMMON, KIND_NUM, COM_RST, 4'h0, 16'h0000));
  endtask
  // ----------------------------------------
  // main sequence and hang guard
  // ----------------------------------------
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    ifc_clear_in = 1'b0;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_count();
    t_cont();
    t_scan();
    t_abort();
    t_clear();
    t_mon();
    t_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
